/* core/adc_capture_params.svh */
// Constants for the converter output control block
`ifndef ADC_CAPTURE_PARAMS_SVH
`define ADC_CAPTURE_PARAMS_SVH
`define SAMPLE_WIDTH 12
`define PIPE_DEPTH 4
`define RECOVER_CYCLES 16
`define MIN_SAMPLE_RATE_KHZ 100
`define MAX_SAMPLE_RATE_KHZ 15000
`define CLK_SYS_KHZ 50000
`define RESET_OE_N 1'b1
`define RESET_UNDEFINED 1'b1
`endif

/* core/adc_capture_pkg.sv */
// Types for the converter output control block
`include "adc_capture_params.svh"
package adc_capture_pkg;
    typedef enum logic [1:0] {run_s, sleep_s, recover_s} power_state_t;
    typedef struct packed {
        logic [`SAMPLE_WIDTH-1:0] code;
        logic valid;
    } sample_t;
    typedef struct packed {
        logic [2:0] float_sync;
        logic [2:0] save_sync;
        logic [2:0] conv_sync;
        logic [`PIPE_DEPTH-1:0][`SAMPLE_WIDTH-1:0] pipe;
        logic [`PIPE_DEPTH-1:0] pipe_ok;
        power_state_t pstate;
        logic [15:0] recover_cnt;
        sample_t out_word;
        logic [`SAMPLE_WIDTH-1:0] data_out;
        logic data_oe_n;
        logic undefined;
    } state_t;
endpackage

/* core/adc_output_capture_ctrl.sv */
// Digital output path of a pipelined 12-bit converter
`timescale 1ns/100ps
`include "adc_capture_params.svh"
module adc_output_capture_ctrl
    import adc_capture_pkg::*;
#(
    parameter int unsigned RECOVER = `RECOVER_CYCLES
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Device pins, asynchronous
    input wire logic sample_clk,
    input wire logic output_float_pin,
    input wire logic power_save_pin,
    // Quantiser result, offset binary
    input wire logic [`SAMPLE_WIDTH-1:0] quant_code,
    // Data pins, enable active low
    output logic [`SAMPLE_WIDTH-1:0] data_out,
    output logic data_oe_n,
    // Status
    output logic data_valid,
    output logic data_undefined
);
    state_t s;
    state_t next_s;
    logic conv_tick;
    logic float_q;
    logic save_q;

    // Shift one pin sample into a synchroniser chain
    function automatic logic [2:0] sync_shift(input logic [2:0] chain,
        input logic pin);
        return {chain[1:0], pin};
    endfunction

    // Word may be trusted only with both control pins low
    function automatic logic word_visible(input logic flt, input logic sav);
        return !flt && !sav;
    endfunction

    function automatic logic is_running(input power_state_t st);
        return st == run_s;
    endfunction

    assign float_q = s.float_sync[1];
    assign save_q = s.save_sync[1];
    // Rising sample clock, read from second and third stages only
    assign conv_tick = s.conv_sync[1] & ~s.conv_sync[2];

    always_comb begin
        next_s = s;
        next_s.float_sync = sync_shift(s.float_sync, output_float_pin);
        next_s.save_sync = sync_shift(s.save_sync, power_save_pin);
        next_s.conv_sync = sync_shift(s.conv_sync, sample_clk);
        case (s.pstate)
            run_s: begin
                if (save_q) begin
                    next_s.pstate = sleep_s;
                end
            end
            sleep_s: begin
                if (!save_q) begin
                    next_s.pstate = recover_s;
                    next_s.recover_cnt = 16'(RECOVER);
                end
            end
            recover_s: begin
                if (save_q) begin
                    next_s.pstate = sleep_s;
                end else if (s.recover_cnt <= 16'h0001) begin
                    next_s.pstate = run_s;
                    next_s.recover_cnt = 16'h0000;
                end else begin
                    next_s.recover_cnt = s.recover_cnt - 16'h0001;
                end
            end
            default: begin
                next_s.pstate = sleep_s;
            end
        endcase
        if (save_q) begin
            next_s.pipe = '0;
            next_s.pipe_ok = '0;
        end else if (conv_tick) begin
            // Code settled long before the synced edge shows up, so the
            // edge serves as the handshake and the word needs no sync
            next_s.pipe = {s.pipe[`PIPE_DEPTH-2:0], quant_code};
            next_s.pipe_ok = {s.pipe_ok[`PIPE_DEPTH-2:0],
                              is_running(s.pstate)};
            next_s.out_word.code = s.pipe[`PIPE_DEPTH-1];
        end
        next_s.out_word.valid = word_visible(float_q, save_q) &&
            is_running(s.pstate) && s.pipe_ok[`PIPE_DEPTH-1];
        next_s.undefined = save_q;
        next_s.data_out = save_q ? '0 : next_s.out_word.code;
        next_s.data_oe_n = float_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '{default: '0, pstate: sleep_s, data_oe_n: `RESET_OE_N,
                   undefined: `RESET_UNDEFINED};
        end else begin
            s <= next_s;
        end
    end

    assign data_out = s.data_out;
    assign data_oe_n = s.data_oe_n;
    assign data_valid = s.out_word.valid;
    assign data_undefined = s.undefined;

    AST_FLOAT_FOLLOWS: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(s.float_sync[1]) |=> data_oe_n)
        else $error("data pins not released");

    AST_DRIVE_FOLLOWS: assert property (
        @(posedge clk_sys) disable iff (rst)
        $fell(s.float_sync[1]) |=> !data_oe_n)
        else $error("data pins not driven");

    AST_FLOAT_KEEPS_CONV: assert property (
        @(posedge clk_sys) disable iff (rst)
        (conv_tick && !save_q) |=> s.pipe[0] == $past(quant_code))
        else $error("conversion stalled");

    AST_SAVE_UNDEF: assert property (
        @(posedge clk_sys) disable iff (rst)
        save_q |=> data_undefined && !data_valid)
        else $error("output not undefined in power save");

    AST_SAVE_SLEEP: assert property (
        @(posedge clk_sys) disable iff (rst)
        save_q |=> s.pstate == sleep_s && data_out == '0)
        else $error("power save not entered");

    AST_PIPE_WIPE: assert property (
        @(posedge clk_sys) disable iff (rst)
        save_q |=> s.pipe_ok == '0)
        else $error("pipeline kept through power save");

    sequence save_exit_s;
        $fell(save_q) ##1 1'b1;
    endsequence

    AST_RECOVER_HOLD: assert property (
        @(posedge clk_sys) disable iff (rst)
        save_exit_s |-> !data_valid [*2])
        else $error("valid during recovery");

    // Leaving sleep must reload the full recovery count
    sequence sleep_exit_s;
        !rst && s.pstate == sleep_s && !save_q;
    endsequence

    sequence recover_loaded_s;
        s.pstate == recover_s && s.recover_cnt == 16'(RECOVER);
    endsequence

    AST_RECOVER_LOAD: assert property (
        @(posedge clk_sys) disable iff (rst)
        sleep_exit_s |=> recover_loaded_s)
        else $error("recovery count not loaded");

    AST_RECOVER_STEP: assert property (
        @(posedge clk_sys) disable iff (rst)
        (s.pstate == recover_s && !save_q && s.recover_cnt > 16'h0001)
        |=> s.recover_cnt == $past(s.recover_cnt) - 16'h0001)
        else $error("recovery count skipped");

    AST_IDLE_INVALID: assert property (
        @(posedge clk_sys) disable iff (rst)
        s.pstate != run_s |=> !data_valid)
        else $error("valid before recovery ended");

    sequence run_tick_s;
        conv_tick && !save_q && s.pstate == run_s;
    endsequence

    AST_FRESH_MARK: assert property (
        @(posedge clk_sys) disable iff (rst)
        run_tick_s |=> s.pipe_ok[0])
        else $error("fresh sample not marked good");

    AST_VALID_GATE: assert property (
        @(posedge clk_sys) disable iff (rst)
        data_valid |-> !$past(float_q) && !$past(save_q))
        else $error("valid with a control pin high");

    AST_WORD_SHOWN: assert property (
        @(posedge clk_sys) disable iff (rst)
        (conv_tick && !save_q) |=>
        data_out == $past(s.pipe[`PIPE_DEPTH-1]))
        else $error("data pins do not carry the new word");

    AST_TICK_UPDATE: assert property (
        @(posedge clk_sys) disable iff (rst)
        (conv_tick && !save_q) |=>
        s.out_word.code == $past(s.pipe[`PIPE_DEPTH-1]))
        else $error("output not updated on sample clock");

    AST_CODE_STEADY: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!conv_tick && !save_q) |=> $stable(s.out_word.code) && $stable(s.pipe))
        else $error("output moved between sample clocks");
endmodule

/* verification/adc_capture_model.sv */
// Capture-side model latching converter words
`timescale 1ns/100ps
`include "adc_capture_params.svh"
module adc_capture_model (
    // Converter pins
    input wire logic sample_clk,
    input wire logic [`SAMPLE_WIDTH-1:0] data_out,
    input wire logic data_oe_n,
    input wire logic data_valid,
    // Captured word
    output logic [`SAMPLE_WIDTH-1:0] held
);
    logic [`SAMPLE_WIDTH-1:0] pin_word;

    // Released pins float, so show junk rather than the last word
    assign pin_word = data_oe_n ? ~data_out : data_out;
    always @(negedge sample_clk) begin
        if (data_valid)
            held <= pin_word;
    end
endmodule

/* verification/adc_output_capture_ctrl_tb.sv */
// Bench for the converter output control block
`timescale 1ns/100ps
`include "adc_capture_params.svh"
module adc_output_capture_ctrl_tb;
    logic clk_sys, rst, output_float_pin, power_save_pin;
    logic sample_clk = 1'b0;
    logic [`SAMPLE_WIDTH-1:0] quant_code, data_out, held;
    logic data_oe_n, data_valid, data_undefined;
    int n_errors = 0, cmp_count = 0, cyc = 0, sc = 0;
    adc_output_capture_ctrl #(.RECOVER(4)) u_dut (.clk_sys(clk_sys),
        .rst(rst), .sample_clk(sample_clk),
        .output_float_pin(output_float_pin),
        .power_save_pin(power_save_pin), .quant_code(quant_code),
        .data_out(data_out), .data_oe_n(data_oe_n),
        .data_valid(data_valid), .data_undefined(data_undefined));
    adc_capture_model u_cap (.sample_clk(sample_clk), .data_out(data_out),
        .data_oe_n(data_oe_n), .data_valid(data_valid), .held(held));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        sc <= (sc == 9) ? 0 : sc + 1;
        sample_clk <= (sc < 5);
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_word(input logic [`SAMPLE_WIDTH-1:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, e);
        chk_word(`SAMPLE_WIDTH'(g), `SAMPLE_WIDTH'(e));
    endtask
    // Sample after the edge's updates have landed
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_word(input logic [`SAMPLE_WIDTH-1:0] c);
        @(posedge clk_sys) quant_code <= c;
        hold(100);
        chk_word(data_out, c);
        chk_word(held, c);
        chk_bit(data_valid, 1'b1);
        chk_bit(data_undefined, 1'b0);
    endtask
    // Word changes while floated, must show within 5 cycles of release
    task automatic t_float();
        @(posedge clk_sys) output_float_pin <= 1'b1;
        @(posedge clk_sys) quant_code <= 12'h3c7;
        hold(80);
        chk_bit(data_oe_n, 1'b1);
        chk_bit(data_valid, 1'b0);
        @(posedge clk_sys) output_float_pin <= 1'b0;
        hold(5);
        chk_bit(data_oe_n, 1'b0);
        chk_word(data_out, 12'h3c7);
    endtask
    task automatic t_save();
        @(posedge clk_sys) power_save_pin <= 1'b1;
        hold(30);
        chk_bit(data_undefined, 1'b1);
        chk_bit(data_valid, 1'b0);
        @(posedge clk_sys) power_save_pin <= 1'b0;
        hold(12);
        chk_bit(data_valid, 1'b0);
        hold(100);
        chk_bit(data_valid, 1'b1);
    endtask
    initial begin
        rst = 1'b1;
        output_float_pin = 1'b0;
        power_save_pin = 1'b0;
        quant_code = 12'h800;
        hold(7);
        chk_bit(data_undefined, 1'b1);
        @(posedge clk_sys) rst <= 1'b0;
        t_word(12'h000);
        t_word(12'hfff);
        t_float();
        t_save();
        t_word(12'ha5c);
        stop_test();
    end
endmodule
